// ### logic/mcmw_pkg.sv
/*
 * Shared constants for the mode command information writer: word layout,
 * structure offsets, mode code values, register map and reset values.
 * Assumes a 16-bit shared RAM with 15-bit word addresses.
 */
//
// Function
// - Gap mode: receive bit13 marks gap errors
// - Broadcast mode: bit13 marks broadcast messages
// - Receive bit12 flags missing or extra word
// - Receive bit11 flags wrong sync on data
// - Bit10 set on any message error
// - Bit9 set when answered with busy
// - Bit8 set when command is illegal
// - Bit5 records bus A or B
// - Bits4-0 hold received mode code
// - Last command, BIT word generated and stored
// - Info at pointer, tag +1, data +2
// - Info and tag written after completion
// - Undefined transmit data codes answered in form
// - Codes without data store no data
// - Gap mode: transmit bit13 flags activity after command
// - Transmit bit12 flags unexpected data words
// - Receive bit14 flags invalid data word
package mcmw_pkg;
    // ==========================================================
    // Information word bit positions
    localparam int BIT_IWD   = 14;
    localparam int BIT_GAP   = 13;
    localparam int BIT_WCT   = 12;
    localparam int BIT_SYN   = 11;
    localparam int BIT_MESSAGE_ERROR_FLAG  = 10;
    localparam int BIT_BUSY  = 9;
    localparam int BIT_ILL   = 8;
    localparam int BIT_BUS   = 5;
    localparam int MC_MSB    = 4;
    // ==========================================================
    // Structure offsets from the data pointer
    localparam logic [14:0] OFS_INFO = 15'h0000;
    localparam logic [14:0] OFS_TAG  = 15'h0001;
    localparam logic [14:0] OFS_DATA = 15'h0002;
    // ==========================================================
    // Mode code values
    localparam logic [4:0] MC_FIRST_DATA = 5'h10;
    localparam logic [4:0] MC_TX_LAST    = 5'h12;
    localparam logic [4:0] MC_TX_BIT     = 5'h13;
    localparam logic [4:0] MC_UNDEF_A    = 5'h11;
    localparam logic [4:0] MC_UNDEF_B    = 5'h14;
    localparam logic [4:0] MC_UNDEF_C    = 5'h15;
    localparam logic [4:0] MC_RX_UNDEF_A = 5'h10;
    localparam logic [4:0] MC_RX_UNDEF_B = 5'h12;
    localparam logic [4:0] MC_RX_UNDEF_C = 5'h13;
    // ==========================================================
    // Register map (word index) and fields
    localparam logic [3:0] REG_CFG   = 4'h0;
    localparam logic [3:0] REG_INFO  = 4'h1;
    localparam logic [3:0] REG_PTR   = 4'h2;
    localparam logic [3:0] REG_COUNT = 4'h3;
    localparam int CFG_BCAST_SEL = 3;
    localparam int CFG_UMC_INV   = 0;
    localparam logic [15:0] CFG_RESET = 16'h0000;
endpackage : mcmw_pkg

// ### logic/mcmw_flag_if.sv
/*
 * Interface between the writer sequencer and its error flag accumulator.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface mcmw_flag_if;
    logic       clr;       // Start of message, clears flags
    logic       ev_gap;    // Gap or bus activity error event
    logic       ev_wct;    // Word count error event
    logic       ev_syn;    // Wrong sync type event
    logic       ev_iwd;    // Manchester or parity error event
    logic       ev_message_error_flag;   // Other message error event
    logic [4:0] flags;     // Sticky flags: message_error_flag, iwd, syn, wct, gap
    modport ctl (output clr, ev_gap, ev_wct, ev_syn, ev_iwd, ev_message_error_flag, input flags);
    modport acc (input clr, ev_gap, ev_wct, ev_syn, ev_iwd, ev_message_error_flag, output flags);
endinterface : mcmw_flag_if

// ### logic/mcmw_flags.sv
/*
 * Sticky per-message error flags. Cleared at message start; an event in
 * the clearing cycle still sets its flag.
 * Assumes events are one-cycle pulses on the system clock.
 */
`timescale 1ns/10ps
module mcmw_flags
    import mcmw_pkg::*;
(
    // Clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RESET_N,
    // Flag link
    mcmw_flag_if.acc  fl
);
    // ==========================================================
    // Flag storage
    logic [4:0] flags_reg;   // Current flags
    logic [4:0] events;      // Incoming events
    logic       message_error_flag_any;    // Any error this cycle

    assign message_error_flag_any = fl.ev_gap | fl.ev_wct | fl.ev_syn | fl.ev_iwd | fl.ev_message_error_flag;
    assign events   = {message_error_flag_any, fl.ev_iwd, fl.ev_syn, fl.ev_wct, fl.ev_gap};
    assign fl.flags = flags_reg;

    // Set wins over clear
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flags_reg <= 5'h00;
        end else begin
            flags_reg <= events | (flags_reg & {5{~fl.clr}});
        end
    end

    // ==========================================================
    // Checks
    property p_wct_sticky;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        fl.ev_wct |=> flags_reg[1] && flags_reg[4];
    endproperty
    a_wct_sticky: assert property (p_wct_sticky) else $error("wct event lost");

    property p_iwd_message_error_flag;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        fl.ev_iwd ##1 !fl.clr |=> flags_reg[3] && flags_reg[4];
    endproperty
    a_iwd_message_error_flag: assert property (p_iwd_message_error_flag) else $error("iwd flag dropped");
endmodule : mcmw_flags

// ### logic/mcmw_writer.sv
/*
 * Mode command structure writer. Captures each mode command, fetches or
 * generates transmit mode data, and after completion writes information
 * word, time tag and mode data word relative to the data pointer.
 * Assumes all protocol inputs come from logic on SYS_CLK and that
 * MSG_DONE never comes before TX_VALID of the same message.
 */
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module mcmw_writer
    import mcmw_pkg::*;
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    // Protocol engine: command
    input  wire logic        MSG_START,
    input  wire logic        CMD_TX,
    input  wire logic [4:0]  CMD_MODE,
    input  wire logic        CMD_BCAST,
    input  wire logic        CMD_BUS_B,
    input  wire logic [14:0] DATA_PTR,
    input  wire logic        ILLEGAL_ENTRY,
    input  wire logic        BUSY_GLOBAL,
    input  wire logic        PER_COMMAND_BUSY,
    input  wire logic [15:0] LAST_CMD_WORD,
    input  wire logic [15:0] BIT_WORD,
    // Protocol engine: events
    input  wire logic        EV_GAP,
    input  wire logic        EV_WORD_COUNT,
    input  wire logic        EV_SYNC,
    input  wire logic        EV_INVALID_WORD,
    input  wire logic        EV_MSG_ERROR,
    input  wire logic        RX_DATA_VALID,
    input  wire logic [15:0] RX_DATA,
    input  wire logic        MSG_DONE,
    input  wire logic [15:0] TIME_TAG,
    // Protocol engine: answers
    output logic             RESPOND_LEGAL,
    output logic             TX_VALID,
    output logic [15:0]      TX_WORD,
    // Shared RAM port
    output logic             RAM_WE,
    output logic             RAM_RE,
    output logic [14:0]      RAM_ADDR,
    output logic [15:0]      RAM_WDATA,
    input  wire logic [15:0] RAM_RDATA,
    // Register port
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [15:0]      REG_RDATA
);
    // ==========================================================
    // Declarations
    typedef enum {ST_IDLE, ST_FETCH, ST_RD1, ST_RD2, ST_SEND, ST_ACTIVE,
                  ST_WR_INFO, ST_WR_TAG, ST_WR_DATA} mcmw_state_t;

    mcmw_state_t state_reg;      // Sequencer state
    mcmw_state_t state_next;     // Next state
    logic        tx_reg;         // Transmit command
    logic [4:0]  mode_reg;       // Captured mode code
    logic        bcast_reg;      // Broadcast command
    logic        bus_b_reg;      // Received on bus B
    logic [14:0] ptr_reg;        // Structure start
    logic        ill_reg;        // Illegal entry
    logic        busy_reg;       // Answered busy
    logic        legal_reg;      // Answered in form
    logic [15:0] data_reg;       // Mode data word
    logic        have_data_reg;  // Data word to store
    logic [15:0] cfg_reg;        // Configuration
    logic [15:0] info_reg;       // Last written info word
    logic [15:0] count_reg;      // Completed messages
    logic [15:0] info_word;      // Composed info word
    logic        undef_cmd;      // Undefined mode command
    logic        legal_now;      // In-form answer at start
    logic        busy_now;       // Busy at start
    logic        internal_now;   // Internally generated data
    logic        has_data_now;   // Code carries data
    logic        bit13;          // Gap or broadcast bit

    mcmw_flag_if fl ();

    // ==========================================================
    // Flag accumulator
    mcmw_flags u_flags (
        .SYS_CLK (SYS_CLK),
        .RESET_N (RESET_N),
        .fl      (fl)
    );

    // Only a taken start clears flags; a refused one leaves them alone
    assign fl.clr     = MSG_START && (state_reg == ST_IDLE);
    assign fl.ev_gap  = EV_GAP;
    assign fl.ev_wct  = EV_WORD_COUNT;
    assign fl.ev_syn  = EV_SYNC;
    assign fl.ev_iwd  = EV_INVALID_WORD;
    assign fl.ev_message_error_flag = EV_MSG_ERROR;

    // ==========================================================
    // Command decode at start
    always_comb begin
        has_data_now = (CMD_MODE >= MC_FIRST_DATA);
        internal_now = CMD_TX && (CMD_MODE == MC_TX_LAST || CMD_MODE == MC_TX_BIT);
        // Undefined codes per direction
        if (CMD_TX) begin
            undef_cmd = (CMD_MODE == MC_UNDEF_A) || (CMD_MODE == MC_UNDEF_B)
                      || (CMD_MODE == MC_UNDEF_C);
        end else begin
            undef_cmd = !has_data_now || (CMD_MODE == MC_RX_UNDEF_A)
                      || (CMD_MODE == MC_RX_UNDEF_B) || (CMD_MODE == MC_RX_UNDEF_C);
        end
        // In form unless illegalized or undefined codes invalidated
        legal_now = !ILLEGAL_ENTRY && !(undef_cmd && cfg_reg[CFG_UMC_INV]);
        busy_now  = BUSY_GLOBAL || PER_COMMAND_BUSY;
    end

    // ==========================================================
    // Information word composition
    always_comb begin
        bit13     = cfg_reg[CFG_BCAST_SEL] ? bcast_reg : fl.flags[0];
        info_word = 16'h0000;
        info_word[BIT_GAP]  = bit13;
        info_word[BIT_WCT]  = fl.flags[1];
        info_word[BIT_MESSAGE_ERROR_FLAG] = fl.flags[4];
        info_word[BIT_BUSY] = busy_reg;
        info_word[BIT_ILL]  = ill_reg;
        info_word[BIT_BUS]  = bus_b_reg;
        info_word[MC_MSB:0] = mode_reg;
        // Receive-only bits; stay zero for transmit
        if (!tx_reg) begin
            info_word[BIT_IWD] = fl.flags[3];
            info_word[BIT_SYN] = fl.flags[2];
        end
    end

    // ==========================================================
    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (MSG_START && CMD_TX && has_data_now && legal_now && !busy_now) begin
                    state_next = internal_now ? ST_SEND : ST_FETCH;
                end else if (MSG_START) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_FETCH:   state_next = ST_RD1;
            ST_RD1:     state_next = ST_RD2;
            ST_RD2:     state_next = ST_SEND;
            ST_SEND:    state_next = ST_ACTIVE;
            ST_ACTIVE: begin
                if (MSG_DONE) begin
                    state_next = ST_WR_INFO;
                end
            end
            ST_WR_INFO: state_next = ST_WR_TAG;
            ST_WR_TAG:  state_next = have_data_reg ? ST_WR_DATA : ST_IDLE;
            ST_WR_DATA: state_next = ST_IDLE;
            default:    state_next = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Command capture
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_reg    <= 1'b0;
            mode_reg  <= 5'h00;
            bcast_reg <= 1'b0;
            bus_b_reg <= 1'b0;
            ptr_reg   <= 15'h0000;
            ill_reg   <= 1'b0;
            busy_reg  <= 1'b0;
            legal_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && MSG_START) begin
            tx_reg    <= CMD_TX;
            mode_reg  <= CMD_MODE;
            bcast_reg <= CMD_BCAST;
            bus_b_reg <= CMD_BUS_B;
            ptr_reg   <= DATA_PTR;
            ill_reg   <= ILLEGAL_ENTRY;
            busy_reg  <= busy_now && legal_now;
            legal_reg <= legal_now;
        end
    end

    // ==========================================================
    // Mode data word: generated, fetched or received
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            data_reg      <= 16'h0000;
            have_data_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && MSG_START) begin
            data_reg      <= (CMD_MODE == MC_TX_LAST) ? LAST_CMD_WORD : BIT_WORD;
            have_data_reg <= internal_now && legal_now && !busy_now;
        end else if (state_reg == ST_RD2) begin
            data_reg <= RAM_RDATA;
        end else if (state_reg == ST_ACTIVE && RX_DATA_VALID && !tx_reg
                     && mode_reg >= MC_FIRST_DATA) begin
            data_reg      <= RX_DATA;
            have_data_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Answers to protocol engine
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESPOND_LEGAL <= 1'b0;
            TX_VALID      <= 1'b0;
            TX_WORD       <= 16'h0000;
        end else begin
            if (state_reg == ST_IDLE && MSG_START) begin
                RESPOND_LEGAL <= legal_now;
            end
            TX_VALID <= (state_reg == ST_SEND);
            if (state_reg == ST_SEND) begin
                TX_WORD <= data_reg;
            end
        end
    end

    // ==========================================================
    // Shared RAM port
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RAM_WE    <= 1'b0;
            RAM_RE    <= 1'b0;
            RAM_ADDR  <= 15'h0000;
            RAM_WDATA <= 16'h0000;
        end else begin
            RAM_WE <= 1'b0;
            RAM_RE <= 1'b0;
            case (state_reg)
                ST_FETCH: begin
                    RAM_RE   <= 1'b1;
                    RAM_ADDR <= ptr_reg + OFS_DATA;
                end
                ST_WR_INFO: begin
                    RAM_WE    <= 1'b1;
                    RAM_ADDR  <= ptr_reg + OFS_INFO;
                    RAM_WDATA <= info_word;
                end
                ST_WR_TAG: begin
                    RAM_WE    <= 1'b1;
                    RAM_ADDR  <= ptr_reg + OFS_TAG;
                    RAM_WDATA <= TIME_TAG;
                end
                ST_WR_DATA: begin
                    RAM_WE    <= 1'b1;
                    RAM_ADDR  <= ptr_reg + OFS_DATA;
                    RAM_WDATA <= data_reg;
                end
                default: begin
                    RAM_WE <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Status capture for software
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            info_reg  <= 16'h0000;
            count_reg <= 16'h0000;
        end else if (state_reg == ST_WR_INFO) begin
            info_reg  <= info_word;
            count_reg <= count_reg + 16'h0001;
        end
    end

    // Configuration write
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_reg <= CFG_RESET;
        end else if (REG_WR && REG_ADDR == REG_CFG) begin
            cfg_reg <= REG_WDATA & ((16'h0001 << CFG_BCAST_SEL) | (16'h0001 << CFG_UMC_INV));
        end
    end

    // Register read, data one cycle later
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                REG_CFG:   REG_RDATA <= cfg_reg;
                REG_INFO:  REG_RDATA <= info_reg;
                REG_PTR:   REG_RDATA <= {1'b0, ptr_reg};
                REG_COUNT: REG_RDATA <= count_reg;
                default:   REG_RDATA <= 16'h0000;
            endcase
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end

    // ==========================================================
    // Checks
    property p_info_after_done;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (state_reg == ST_ACTIVE && MSG_DONE) |-> ##2 (RAM_WE && RAM_ADDR == ptr_reg);
    endproperty
    a_info_after_done: assert property (p_info_after_done) else $error("info late");

    property p_tag_addr;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (state_reg == ST_ACTIVE && MSG_DONE) |-> ##3
            (RAM_WE && RAM_ADDR == ptr_reg + 15'h0001 && RAM_WDATA == $past(TIME_TAG));
    endproperty
    a_tag_addr: assert property (p_tag_addr) else $error("time tag misplaced");

    property p_no_data_low;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (state_reg == ST_ACTIVE && MSG_DONE && mode_reg < MC_FIRST_DATA) |-> ##4 !RAM_WE;
    endproperty
    a_no_data_low: assert property (p_no_data_low) else $error("data word for low code");

    property p_mode_field;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        $past(state_reg == ST_WR_INFO) |-> (RAM_WDATA[4:0] == mode_reg
            && RAM_WDATA[5] == bus_b_reg && RAM_WDATA[8] == ill_reg);
    endproperty
    a_mode_field: assert property (p_mode_field) else $error("mode bits wrong");

    property p_unused_zero;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        $past(state_reg == ST_WR_INFO) |-> (RAM_WDATA[15] == 1'b0 && RAM_WDATA[7:6] == 2'b00
            && (!tx_reg || (RAM_WDATA[14] == 1'b0 && RAM_WDATA[11] == 1'b0)));
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

    property p_internal_data;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (state_reg == ST_IDLE && MSG_START && CMD_TX && CMD_MODE == MC_TX_LAST
            && legal_now && !busy_now) |-> ##2 (TX_VALID && TX_WORD == $past(LAST_CMD_WORD, 2));
    endproperty
    a_internal_data: assert property (p_internal_data) else $error("last cmd not sent");

    property p_bit13_select;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        $past(state_reg == ST_WR_INFO) && $past(cfg_reg[CFG_BCAST_SEL])
            |-> RAM_WDATA[13] == bcast_reg;
    endproperty
    a_bit13_select: assert property (p_bit13_select) else $error("broadcast bit wrong");

    property p_busy_bit;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        $past(state_reg == ST_WR_INFO) |-> RAM_WDATA[9] == busy_reg
            && (!busy_reg || legal_reg) && RAM_WDATA[10] == $past(fl.flags[4]);
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy or error bit wrong");

    property p_in_form;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (state_reg == ST_IDLE && MSG_START && CMD_TX && CMD_MODE == MC_UNDEF_A
            && !ILLEGAL_ENTRY && !cfg_reg[CFG_UMC_INV]) |=> RESPOND_LEGAL;
    endproperty
    a_in_form: assert property (p_in_form) else $error("undefined code refused");
endmodule : mcmw_writer

// ### test/mcmw_ram_model.sv
/* Shared RAM partner of the writer: preset words, one-cycle reads.
   Assumes the writer's RAM port on the same clock. */
`timescale 1ns/10ps
module mcmw_ram_model (
    // Clock
    input  wire logic        clk,
    // Port
    input  wire logic        we,
    input  wire logic        re,
    input  wire logic [14:0] addr,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata
);
    logic [15:0] mem [0:32767]; // Word store
    // Host preloads every word, transmit data included
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 16'(i) ^ 16'hA5C3;
        end
    end
    // Write; read data only after a read, else churn
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= re ? mem[addr] : ~mem[addr];
    end
endmodule : mcmw_ram_model

// ### test/test_mode_cmd_msg_info_writer.sv
/* Bench of the mode command writer: random messages, model compare.
   Assumes the RAM partner model beside the writer. */
`timescale 1ns/10ps
module test_mode_cmd_msg_info_writer;
    import mcmw_pkg::*;
    logic clk = 0, rst_n = 0, st = 0, tx = 0, bc = 0, bb = 0, il = 0, bg = 0, pb = 0;
    logic rxv = 0, done = 0, wr = 0, rd = 0, we, re, leg, txv;
    logic [4:0] mc = 0, ev = 0;
    logic [3:0] ra = 0;
    logic [14:0] ptr = 0, addr;
    logic [15:0] lcw = 0, bw = 0, rxd = 0, tag = 0, rwd = 0, rdat, wdat, txw, regd;
    logic [31:0] rnd = 32'h1374;
    int num_errors = 0, samples_checked = 0, cyc = 0;
    mcmw_writer uut (.SYS_CLK(clk), .RESET_N(rst_n), .MSG_START(st), .CMD_TX(tx),
        .CMD_MODE(mc), .CMD_BCAST(bc), .CMD_BUS_B(bb), .DATA_PTR(ptr), .ILLEGAL_ENTRY(il),
        .BUSY_GLOBAL(bg), .PER_COMMAND_BUSY(pb), .LAST_CMD_WORD(lcw), .BIT_WORD(bw),
        .EV_GAP(ev[0]), .EV_WORD_COUNT(ev[1]), .EV_SYNC(ev[2]), .EV_INVALID_WORD(ev[3]),
        .EV_MSG_ERROR(ev[4]), .RX_DATA_VALID(rxv), .RX_DATA(rxd), .MSG_DONE(done),
        .TIME_TAG(tag), .RESPOND_LEGAL(leg), .TX_VALID(txv), .TX_WORD(txw), .RAM_WE(we),
        .RAM_RE(re), .RAM_ADDR(addr), .RAM_WDATA(wdat), .RAM_RDATA(rdat), .REG_ADDR(ra),
        .REG_WDATA(rwd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(regd));
    mcmw_ram_model ram (.clk(clk), .we(we), .re(re), .addr(addr), .wdata(wdat),
        .rdata(rdat));
    always #10 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            num_errors++;
            summarize();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [15:0] ini(input logic [14:0] a);
        return {1'b0, a} ^ 16'hA5C3;
    endfunction : ini
    task automatic cmp(input logic [15:0] e, input logic [15:0] a);
        samples_checked++;
        if (a !== e) begin
            num_errors++;
            $display("[ERR] %0t expected %h got %h", $time, e, a);
        end
    endtask : cmp
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk) begin rd <= 1; ra <= a; end
        @(posedge clk) rd <= 0;
        #1 cmp(e, regd);
    endtask : reg_rd
    // One mode command with model of its stored structure
    task automatic msg(input int i);
        logic [15:0] info, etx;
        logic [4:0] evs;
        logic cf3, cf0, und, lg, by, txe, dw;
        rnd = lfsr(rnd);
        @(posedge clk) begin wr <= 1; ra <= REG_CFG; rwd <= rnd[31:16]; end
        @(posedge clk) wr <= 0;
        reg_rd(REG_CFG, rnd[31:16] & 16'h0009);
        cf3 = rnd[19];
        cf0 = rnd[16];
        rnd = lfsr(rnd);
        evs = rnd[18:14] & rnd[23:19];
        @(posedge clk) begin
            st <= 1; tx <= (i < 4) | rnd[0]; mc <= (i < 4) ? 5'h12 + 5'(i % 2) : rnd[5:1];
            bc <= rnd[6]; bb <= rnd[7]; il <= rnd[8] & rnd[9]; bg <= rnd[10] & rnd[11];
            pb <= rnd[12] & rnd[13]; ptr <= 15'h0500 + 15'(4 * i); lcw <= rnd[31:16];
            bw <= ~rnd[31:16]; tag <= rnd[15:0]; rxd <= {rnd[7:0], rnd[31:24]};
        end
        @(posedge clk) begin st <= 0; ev <= evs; rxv <= !tx && mc >= 5'h10; end
        @(posedge clk) begin ev <= 0; rxv <= 0; end
        und = tx ? (mc == 5'h11 || mc == 5'h14 || mc == 5'h15) : (mc < 5'h14 && mc != 5'h11);
        lg = !il && !(und && cf0);
        by = (bg | pb) && lg;
        txe = tx && mc >= 5'h10 && lg && !by;
        dw = tx ? txe && (mc == 5'h12 || mc == 5'h13) : mc >= 5'h10;
        etx = tx ? (mc == 5'h12 ? lcw : mc == 5'h13 ? bw : ini(ptr + 15'h2)) : rxd;
        info = {1'b0, !tx & evs[3], cf3 ? bc : evs[0], evs[1], !tx & evs[2], |evs, by, il,
            2'b00, bb, mc};
        if (txe) begin
            #1;
            for (int k = 0; k < 12 && txv !== 1'b1; k++) @(posedge clk) #1;
            cmp(16'h0001, {15'h0, txv});
            cmp(etx, txw);
        end
        cmp({15'h0, lg}, {15'h0, leg});
        cmp(ini(ptr), ram.mem[ptr]);
        @(posedge clk) done <= 1;
        @(posedge clk) done <= 0;
        repeat (6) @(posedge clk);
        #1 cmp(info, ram.mem[ptr]);
        cmp(info & 16'hE000, ram.mem[ptr] & 16'hE000);
        cmp(tag, ram.mem[ptr + 15'h1]);
        cmp(dw ? etx : ini(ptr + 15'h2), ram.mem[ptr + 15'h2]);
        reg_rd(REG_INFO, info);
        reg_rd(REG_PTR, {1'b0, ptr});
        reg_rd(REG_COUNT, 16'(i + 1));
    endtask : msg
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // Reset, register map, then random mode commands
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        reg_rd(REG_CFG, CFG_RESET);
        reg_rd(4'hA, 16'h0000);
        for (int i = 0; i < 48; i++) msg(i);
        summarize();
    end
endmodule : test_mode_cmd_msg_info_writer
